/* File: capture_pkg.sv */
// Shared constants, types and helpers for the trace capture controller
package capture_pkg;
  localparam int DATA_W = 32;
  localparam int FIFO_DEPTH = 8;
  localparam int STORE_DEPTH = 16;
  localparam int PTR_W = 4;
  localparam int LVL_W = 5;
  localparam int MEM_IDX_W = 10;
  localparam int MEM_PTR_W = 11;
  localparam logic [MEM_PTR_W-1:0] MEM_WORDS = 11'h400;
  localparam logic [DATA_W-1:0] EMPTY_READ = 32'hffffffff;
  localparam logic [LVL_W-1:0] STORE_FULL = 5'h10;
  localparam logic [3:0] FULL_STROBE = 4'hf;
  localparam logic [1:0] OKAY_RESP = 2'h0;

  typedef enum logic [1:0] {
    sram_buffer_variant,
    sram_fifo_variant,
    axi_memory_variant,
    stream_out_variant
  } variant_e;

  typedef enum logic [1:0] {
    circular_capture_mode,
    hw_read_fifo_mode,
    sw_read_fifo_one,
    sw_read_fifo_two
  } mode_e;

  localparam mode_e MODE_AFTER_RESET = circular_capture_mode;

  // Which capture modes a build variant can run
  function automatic logic mode_supported(input variant_e v, input mode_e m);
    case (m)
      circular_capture_mode: mode_supported = 1'b1;
      hw_read_fifo_mode: mode_supported = (v == sram_fifo_variant);
      sw_read_fifo_one: mode_supported = (v != stream_out_variant);
      sw_read_fifo_two: mode_supported = (v == axi_memory_variant);
      default: mode_supported = 1'b0;
    endcase
  endfunction

  // Storage index step with wrap
  function automatic logic [PTR_W-1:0] step_ptr(input logic [PTR_W-1:0] p);
    step_ptr = p + 4'h1;
  endfunction
endpackage

/* File: stage_fifo.sv */
// Parameterised flip-flop FIFO with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
module stage_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 8
) (
  input wire logic clk_sys,        // System clock
  input wire logic reset_n,        // Asynchronous reset, active low
  trace_stream_if.sink fill,       // Filling side
  trace_stream_if.source drain     // Draining side
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [AW-1:0] LAST_IDX = AW'(DEPTH - 1);
  localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_idx;
  logic [AW-1:0] rd_idx;
  logic [CW-1:0] count;
  logic do_push;
  logic do_pop;

  assign fill.ready = (count != FULL_CNT);
  assign drain.valid = (count != '0);
  assign drain.data = mem[rd_idx];
  assign do_push = fill.valid && fill.ready;
  assign do_pop = drain.valid && drain.ready;

  always_ff @(posedge clk_sys) begin
    if (do_push) begin
      mem[wr_idx] <= fill.data;
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      wr_idx <= '0;
      rd_idx <= '0;
      count <= '0;
    end else begin
      if (do_push) begin
        wr_idx <= (wr_idx == LAST_IDX) ? '0 : wr_idx + 1'b1;
      end
      if (do_pop) begin
        rd_idx <= (rd_idx == LAST_IDX) ? '0 : rd_idx + 1'b1;
      end
      if (do_push && !do_pop) begin
        count <= count + 1'b1;
      end else if (do_pop && !do_push) begin
        count <= count - 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

/* File: trace_capture.sv */
// Trace capture controller: staging FIFO, capture storage and drain paths
`timescale 1ns/1ps
`default_nettype none
module trace_capture #(
  parameter capture_pkg::variant_e VARIANT = capture_pkg::sram_fifo_variant
) (
  input wire logic clk_sys,                               // System clock, 20 MHz
  input wire logic reset_n,                               // Asynchronous reset, active low
  input wire logic trace_valid,                           // Trace bus word valid
  output logic trace_ready,                               // Trace bus flow control
  input wire logic [capture_pkg::DATA_W-1:0] trace_data,  // Trace bus word
  input wire logic trigger_in,                            // Trigger indication
  input wire logic capture_enable,                        // Capture session enable
  input wire logic stop_on_trigger,                       // End capture on trigger in circular mode
  input wire logic [1:0] mode_select,                     // Requested capture mode
  output logic [1:0] mode_active,                         // Mode in force
  output logic capture_ready,                             // No capture session running
  output logic triggered,                                 // Trigger seen this session
  output logic [capture_pkg::LVL_W-1:0] store_level,      // Words held in the store
  output logic sink_valid,                                // Trace sink word valid
  input wire logic sink_ready,                            // Trace sink ready
  output logic [capture_pkg::DATA_W-1:0] sink_data,       // Trace sink word
  input wire logic rrd_read,                              // RAM read data register read
  output logic [capture_pkg::DATA_W-1:0] ram_read_data_reg, // Read data answer
  output logic rrd_valid,                                 // Read data answer valid
  input wire logic rurp_valid,                            // Debugger read report strobe
  input wire logic [capture_pkg::MEM_IDX_W-1:0] rurp_words, // Words taken from memory
  input wire logic [31:0] mem_base,                       // Trace memory byte base
  output logic [capture_pkg::MEM_PTR_W-1:0] mem_read_ptr, // Memory read pointer
  output logic [capture_pkg::MEM_PTR_W-1:0] mem_write_ptr, // Memory write pointer
  output logic awvalid,                                   // AXI write address valid
  input wire logic awready,                               // AXI write address ready
  output logic [31:0] awaddr,                             // AXI write address
  output logic wvalid,                                    // AXI write data valid
  input wire logic wready,                                // AXI write data ready
  output logic [capture_pkg::DATA_W-1:0] wdata,           // AXI write data
  output logic [3:0] wstrb,                               // AXI write strobes
  output logic wlast,                                     // AXI last beat
  input wire logic bvalid,                                // AXI write response valid
  output logic bready,                                    // AXI write response ready
  input wire logic [1:0] bresp,                           // AXI write response
  output logic tvalid,                                    // Stream word valid
  input wire logic tready,                                // Stream ready
  output logic [capture_pkg::DATA_W-1:0] tdata,           // Stream word
  output logic tlast                                      // Stream last word of drain
);
  typedef enum logic [1:0] {st_idle, st_capture, st_done} state_e;

  trace_stream_if #(.WIDTH(capture_pkg::DATA_W)) in_if ();
  trace_stream_if #(.WIDTH(capture_pkg::DATA_W)) out_if ();

  state_e state;
  capture_pkg::mode_e mode;
  logic cap_en_q;
  logic start;
  logic trig_stop;
  logic [capture_pkg::DATA_W-1:0] store [capture_pkg::STORE_DEPTH];
  logic [capture_pkg::PTR_W-1:0] wr_ptr;
  logic [capture_pkg::PTR_W-1:0] rd_ptr;
  logic [capture_pkg::LVL_W-1:0] level;
  logic full;
  logic empty;
  logic push;
  logic overwrite;
  logic to_sw;
  logic to_sink;
  logic to_axi;
  logic to_axis;
  logic drain_ok;
  logic mem_room;
  logic [capture_pkg::MEM_PTR_W-1:0] mem_fill;
  logic out_valid;
  logic [capture_pkg::DATA_W-1:0] out_data;
  logic out_last;
  logic out_taken;
  logic load;
  logic sw_pop;
  logic pop;
  logic aw_pend;
  logic w_pend;
  logic b_ok;
  logic [capture_pkg::MEM_PTR_W-1:0] wr_slot;

  // Trace bus feeds the staging FIFO; its ready is the source's flow control
  assign in_if.valid = trace_valid;
  assign in_if.data = trace_data;
  assign trace_ready = in_if.ready;

  stage_fifo #(.WIDTH(capture_pkg::DATA_W), .DEPTH(capture_pkg::FIFO_DEPTH)) u_stage (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .fill(in_if),
    .drain(out_if)
  );

  assign start = capture_enable && !cap_en_q;
  assign trig_stop = (mode == capture_pkg::circular_capture_mode) && stop_on_trigger && trigger_in;

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      cap_en_q <= 1'b0;
    end else begin
      cap_en_q <= capture_enable;
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      state <= st_idle;
    end else begin
      case (state)
        st_idle: begin
          if (start) begin
            state <= st_capture;
          end
        end
        st_capture: begin
          // stop on trigger or on disable
          if (!capture_enable || trig_stop) begin
            state <= st_done;
          end
        end
        st_done: begin
          if (start) begin
            state <= st_capture;
          end
        end
        default: state <= st_idle;
      endcase
    end
  end

  // mode taken only when supported and not capturing
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      mode <= capture_pkg::MODE_AFTER_RESET;
    end else if (state != st_capture &&
                 capture_pkg::mode_supported(VARIANT, capture_pkg::mode_e'(mode_select))) begin
      mode <= capture_pkg::mode_e'(mode_select);
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      triggered <= 1'b0;
    end else if (start) begin
      triggered <= 1'b0;
    end else if (state == st_capture && trigger_in) begin
      triggered <= 1'b1;
    end
  end

  assign full = (level == capture_pkg::STORE_FULL);
  assign empty = (level == '0);

  // circular mode always takes; other modes stall on a full store
  assign out_if.ready = (state != st_capture) ||
                        (mode == capture_pkg::circular_capture_mode) || !full;
  assign push = out_if.valid && out_if.ready && (state == st_capture);
  assign overwrite = push && full;

  // software read destination; buffer variant drains by reads
  assign to_sw = (mode == capture_pkg::sw_read_fifo_one) ||
                 (mode == capture_pkg::circular_capture_mode &&
                  VARIANT == capture_pkg::sram_buffer_variant);
  // sink output only in the FIFO variant
  assign to_sink = !to_sw && (VARIANT == capture_pkg::sram_fifo_variant);
  // AXI memory path in the AXI variant
  assign to_axi = !to_sw && (VARIANT == capture_pkg::axi_memory_variant);
  // stream output in the stream variant
  assign to_axis = (VARIANT == capture_pkg::stream_out_variant);
  // circular drain waits for the end of capture
  assign drain_ok = (mode == capture_pkg::circular_capture_mode) ? (state == st_done) : 1'b1;

  assign mem_fill = mem_write_ptr - mem_read_ptr;
  // Next memory slot, counting a response taken in the same cycle as a load
  assign wr_slot = (bvalid && b_ok) ? mem_write_ptr + 11'h1 : mem_write_ptr;
  // memory used as FIFO must not overflow in mode two
  assign mem_room = (mode != capture_pkg::sw_read_fifo_two) || (mem_fill < capture_pkg::MEM_WORDS);

  assign b_ok = to_axi && out_valid && !aw_pend && !w_pend;
  assign bready = b_ok;
  assign out_taken = to_axi ? (bvalid && b_ok) :
                     to_sink ? sink_ready :
                     to_axis ? tready : 1'b0;
  assign load = drain_ok && !empty && !to_sw && (to_sink || to_axi || to_axis) &&
                (!out_valid || out_taken) && mem_room;
  // register read pops in mode one or after a circular session
  assign sw_pop = to_sw && rrd_read && !empty &&
                  ((mode == capture_pkg::sw_read_fifo_one) || state == st_done);
  assign pop = load || sw_pop;

  always_ff @(posedge clk_sys) begin
    if (push) begin
      store[wr_ptr] <= out_if.data;
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      level <= '0;
    end else if (start) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      level <= '0;
    end else begin
      if (push) begin
        wr_ptr <= capture_pkg::step_ptr(wr_ptr);
      end
      // read side skips the overwritten word
      if (pop || overwrite) begin
        rd_ptr <= capture_pkg::step_ptr(rd_ptr);
      end
      if (push && !overwrite && !pop) begin
        level <= level + 5'h1;
      end else if (pop && !push) begin
        level <= level - 5'h1;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      ram_read_data_reg <= '0;
      rrd_valid <= 1'b0;
    end else begin
      rrd_valid <= rrd_read;
      if (rrd_read) begin
        ram_read_data_reg <= empty ? capture_pkg::EMPTY_READ : store[rd_ptr];
      end
    end
  end

  // Output stage shared by sink, stream and AXI paths
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      out_valid <= 1'b0;
      out_data <= '0;
      out_last <= 1'b0;
    end else if (load) begin
      out_valid <= 1'b1;
      out_data <= store[rd_ptr];
      out_last <= (level == 5'h1) && (mode == capture_pkg::circular_capture_mode);
    end else if (out_taken) begin
      out_valid <= 1'b0;
    end
  end

  // one single-beat AXI write per word
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      aw_pend <= 1'b0;
      w_pend <= 1'b0;
      awaddr <= '0;
    end else if (load && to_axi) begin
      aw_pend <= 1'b1;
      w_pend <= 1'b1;
      awaddr <= mem_base + {20'h0, wr_slot[capture_pkg::MEM_IDX_W-1:0], 2'h0};
    end else begin
      if (aw_pend && awready) begin
        aw_pend <= 1'b0;
      end
      if (w_pend && wready) begin
        w_pend <= 1'b0;
      end
    end
  end

  // device owns the memory pointers; debugger report advances read
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      mem_write_ptr <= '0;
      mem_read_ptr <= '0;
    end else if (start) begin
      mem_write_ptr <= '0;
      mem_read_ptr <= '0;
    end else begin
      if (bvalid && b_ok) begin
        mem_write_ptr <= mem_write_ptr + 11'h1;
      end
      if (rurp_valid && mode == capture_pkg::sw_read_fifo_two) begin
        mem_read_ptr <= mem_read_ptr + {1'b0, rurp_words};
      end
    end
  end

  assign awvalid = aw_pend;
  assign wvalid = w_pend;
  assign wdata = out_data;
  assign wstrb = capture_pkg::FULL_STROBE;
  assign wlast = 1'b1;
  assign sink_valid = out_valid && to_sink;
  assign sink_data = out_data;
  assign tvalid = out_valid && to_axis;
  assign tdata = out_data;
  assign tlast = out_last;
  assign mode_active = mode;
  assign capture_ready = (state != st_capture);
  assign store_level = level;
endmodule
`default_nettype wire

/* File: trace_capture_sva.sv */
// Port-level assertions for the trace capture controller
`timescale 1ns/1ps
`default_nettype none
module trace_capture_sva #(
  parameter capture_pkg::variant_e VARIANT = capture_pkg::sram_fifo_variant
) (
  input wire logic clk_sys, // System clock
  input wire logic reset_n, // Reset, active low
  input wire logic trigger_in, // Trigger indication
  input wire logic capture_enable, // Session enable
  input wire logic stop_on_trigger, // Stop on trigger
  input wire logic [1:0] mode_active, // Mode in force
  input wire logic capture_ready, // Not capturing
  input wire logic triggered, // Trigger seen
  input wire logic [capture_pkg::LVL_W-1:0] store_level, // Store fill
  input wire logic sink_valid, // Sink word valid
  input wire logic sink_ready, // Sink ready
  input wire logic [capture_pkg::DATA_W-1:0] sink_data, // Sink word
  input wire logic rrd_read, // Register read
  input wire logic [capture_pkg::DATA_W-1:0] ram_read_data_reg, // Read answer
  input wire logic rrd_valid // Read answer valid
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!reset_n);
  logic circ, hw;
  assign circ = (mode_active == capture_pkg::circular_capture_mode);
  assign hw = (mode_active == capture_pkg::hw_read_fifo_mode);

  AST_CIRC_SILENT: assert property (circ && !capture_ready |-> !sink_valid)
    else $error("output during circular capture");
  AST_CIRC_WRAP: assert property (circ && !capture_ready && capture_enable && !trigger_in
    && store_level == capture_pkg::STORE_FULL |=> store_level == capture_pkg::STORE_FULL)
    else $error("full circular store stopped wrapping");
  AST_TRIG_STOP: assert property (circ && stop_on_trigger && trigger_in && !capture_ready
    |=> capture_ready && triggered)
    else $error("trigger did not end capture");
  AST_EMPTY_READ: assert property (rrd_read && capture_ready && store_level == 5'h0
    |=> rrd_valid && ram_read_data_reg == capture_pkg::EMPTY_READ)
    else $error("empty read not all ones");
  AST_SWF_POP: assert property (rrd_read && capture_ready && store_level != 5'h0
    && mode_active == capture_pkg::sw_read_fifo_one
    |=> rrd_valid && store_level == $past(store_level) - 5'h1)
    else $error("register read did not pop one word");
  AST_MODE_HOLD: assert property (!capture_ready |=> $stable(mode_active))
    else $error("mode changed during capture");
  AST_NO_MODE_TWO: assert property (VARIANT != capture_pkg::axi_memory_variant
    |-> mode_active != capture_pkg::sw_read_fifo_two)
    else $error("unsupported mode two in force");
  AST_HW_ONLY_FIFO: assert property (hw |-> VARIANT == capture_pkg::sram_fifo_variant)
    else $error("hardware fifo mode on wrong variant");
  AST_SINK_HOLD: assert property (sink_valid && !sink_ready
    |=> sink_valid && $stable(sink_data))
    else $error("sink word dropped before taken");

  cover property (hw && !capture_ready && store_level == capture_pkg::STORE_FULL);
  cover property (circ && stop_on_trigger && trigger_in && !capture_ready);
  cover property (rrd_read && capture_ready && store_level == 5'h0);
endmodule

bind trace_capture trace_capture_sva #(.VARIANT(VARIANT)) trace_capture_sva_inst (
  .clk_sys(clk_sys), .reset_n(reset_n), .trigger_in(trigger_in),
  .capture_enable(capture_enable), .stop_on_trigger(stop_on_trigger),
  .mode_active(mode_active), .capture_ready(capture_ready), .triggered(triggered),
  .store_level(store_level), .sink_valid(sink_valid), .sink_ready(sink_ready),
  .sink_data(sink_data), .rrd_read(rrd_read), .ram_read_data_reg(ram_read_data_reg),
  .rrd_valid(rrd_valid)
);
`default_nettype wire

/* File: trace_capture_tb_top.sv */
// Self-checking bench for the trace capture controller
`timescale 1ns/1ps
`default_nettype none
module trace_capture_tb_top;
  logic clk_sys, reset_n, trace_valid, trace_ready, trigger_in, capture_enable;
  logic stop_on_trigger, capture_ready, triggered, sink_valid, sink_ready, rrd_read, rrd_valid;
  logic axi_ack, rurp_valid;
  logic [9:0] rurp_words;
  logic [1:0] axi_mode;
  logic [10:0] axi_rd_ptr, axi_wr_ptr;
  logic [31:0] axi_addr, axi_wdata;
  logic [1:0] mode_select, mode_active, pace;
  logic [4:0] store_level;
  logic [31:0] trace_data, sink_data, ram_read_data_reg;
  int n_mismatch, tests_run, acc, base;
  typedef struct {logic [1:0] sel; logic [1:0] act;} row_s;
  row_s rows [4] = '{'{2'h1, 2'h1}, '{2'h2, 2'h2}, '{2'h3, 2'h2}, '{2'h0, 2'h0}};

  trace_capture trace_capture_inst (
    .clk_sys(clk_sys), .reset_n(reset_n), .trace_valid(trace_valid),
    .trace_ready(trace_ready), .trace_data(trace_data), .trigger_in(trigger_in),
    .capture_enable(capture_enable), .stop_on_trigger(stop_on_trigger),
    .mode_select(mode_select), .mode_active(mode_active), .capture_ready(capture_ready),
    .triggered(triggered), .store_level(store_level), .sink_valid(sink_valid),
    .sink_ready(sink_ready), .sink_data(sink_data), .rrd_read(rrd_read),
    .ram_read_data_reg(ram_read_data_reg), .rrd_valid(rrd_valid), .rurp_valid(rurp_valid),
    .rurp_words(rurp_words), .mem_base(32'h0), .mem_read_ptr(), .mem_write_ptr(),
    .awvalid(), .awready(axi_ack), .awaddr(), .wvalid(), .wready(axi_ack), .wdata(),
    .wstrb(), .wlast(), .bvalid(axi_ack), .bready(), .bresp(2'h0), .tvalid(),
    .tready(axi_ack), .tdata(), .tlast()
  );
  trace_capture #(.VARIANT(capture_pkg::axi_memory_variant)) trace_capture_axi_inst (
    .clk_sys(clk_sys), .reset_n(reset_n), .trace_valid(trace_valid), .trace_ready(),
    .trace_data(trace_data), .trigger_in(trigger_in), .capture_enable(capture_enable),
    .stop_on_trigger(stop_on_trigger), .mode_select(mode_select), .mode_active(axi_mode),
    .capture_ready(), .triggered(), .store_level(), .sink_valid(), .sink_ready(1'b0),
    .sink_data(), .rrd_read(rrd_read), .ram_read_data_reg(), .rrd_valid(),
    .rurp_valid(rurp_valid), .rurp_words(rurp_words), .mem_base(32'h0),
    .mem_read_ptr(axi_rd_ptr), .mem_write_ptr(axi_wr_ptr), .awvalid(), .awready(axi_ack),
    .awaddr(axi_addr), .wvalid(), .wready(axi_ack), .wdata(axi_wdata), .wstrb(), .wlast(),
    .bvalid(axi_ack), .bready(), .bresp(2'h0), .tvalid(), .tready(axi_ack), .tdata(),
    .tlast()
  );
  trace_sink_model trace_sink_model_inst (
    .clk_sys(clk_sys), .reset_n(reset_n), .pace(pace), .sink_valid(sink_valid),
    .sink_data(sink_data), .sink_ready(sink_ready)
  );

  task automatic results();
    $display("checks %0d, mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic fail(input string msg);
    n_mismatch++;
    $display("CHECK FAILED t=%0t %s", $time, msg);
  endtask
  task automatic chk_w(input logic [31:0] got, input logic [31:0] exp, input string msg);
    tests_run++;
    if (got !== exp) fail(msg);
  endtask
  task automatic chk_b(input logic got, input logic exp, input string msg);
    tests_run++;
    if (got !== exp) fail(msg);
  endtask
  task automatic limit(input int k, input string msg);
    if (k >= 300) begin
      fail(msg);
      results();
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #2;
  endtask
  task automatic send(input logic [31:0] w);
    int k = 0;
    trace_valid = 1'b1;
    trace_data = w;
    while (trace_ready !== 1'b1 && k < 300) begin
      tick(1);
      k++;
    end
    limit(k, "trace bus timeout");
    tick(1);
  endtask
  task automatic start(input logic [1:0] m);
    mode_select = m;
    tick(2);
    capture_enable = 1'b1;
    tick(1);
  endtask
  task automatic rd(input logic [31:0] exp);
    rrd_read = 1'b1;
    tick(1);
    chk_b(rrd_valid, 1'b1, "read answer missing");
    chk_w(ram_read_data_reg, exp, "read data");
    rrd_read = 1'b0;
    tick(1);
  endtask
  task automatic wait_got(input int n);
    int k = 0;
    while (trace_sink_model_inst.n_got < n && k < 300) begin
      tick(1);
      k++;
    end
    limit(k, "sink timeout");
  endtask

  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = !clk_sys;
  end
  initial begin
    #2000000;
    fail("run timeout");
    results();
  end
  initial begin
    {reset_n, trace_valid, trigger_in, capture_enable, stop_on_trigger, rrd_read} = '0;
    {mode_select, pace, trace_data, axi_ack} = {2'h0, 2'h0, 32'h0, 1'b1};
    rurp_valid = 1'b0;
    rurp_words = 10'h0;
    {n_mismatch, tests_run} = '0;
    tick(3);
    reset_n = 1'b1;
    chk_w({24'h0, capture_ready, trace_ready, sink_valid, store_level}, 32'hc0, "reset");
    chk_w({30'h0, mode_active}, 32'h0, "reset mode");
    $display("test reset done");
    foreach (rows[i]) begin
      mode_select = rows[i].sel;
      tick(2);
      chk_w({30'h0, mode_active}, {30'h0, rows[i].act}, "mode in force");
    end
    $display("test mode table done");
    start(2'h2);
    mode_select = 2'h0;
    for (int i = 0; i < 3; i++) send(32'ha0 + i);
    trace_valid = 1'b0;
    tick(3);
    chk_w({30'h0, mode_active}, 32'h2, "mode switched in capture");
    chk_w({27'h0, store_level}, 32'h3, "store level");
    mode_select = 2'h2;
    capture_enable = 1'b0;
    tick(1);
    for (int i = 0; i < 3; i++) rd(32'ha0 + i);
    rd(capture_pkg::EMPTY_READ);
    $display("test software read done");
    pace = 2'h2;
    start(2'h1);
    acc = 0;
    trace_valid = 1'b1;
    repeat (40) begin
      trace_data = 32'h100 + acc;
      base = int'(trace_ready === 1'b1);
      tick(1);
      acc += base;
    end
    chk_b(trace_ready, 1'b0, "no stall when full");
    chk_w({27'h0, store_level}, {27'h0, capture_pkg::STORE_FULL}, "full level");
    chk_b(acc >= 24, 1'b1, "refused too early");
    trace_valid = 1'b0;
    pace = 2'h1;
    wait_got(acc);
    for (int i = 0; i < acc; i++) chk_w(trace_sink_model_inst.got[i], 32'h100 + i, "hw");
    capture_enable = 1'b0;
    $display("test hardware fifo done");
    pace = 2'h0;
    stop_on_trigger = 1'b1;
    start(2'h0);
    chk_w({30'h0, axi_mode}, 32'h0, "circular on memory variant");
    base = trace_sink_model_inst.n_got;
    for (int i = 0; i < 20; i++) send(32'h200 + i);
    trace_valid = 1'b0;
    tick(4);
    chk_w({27'h0, store_level}, {27'h0, capture_pkg::STORE_FULL}, "wrap level");
    chk_w(trace_sink_model_inst.n_got, base, "output while capturing");
    trigger_in = 1'b1;
    tick(1);
    trigger_in = 1'b0;
    tick(1);
    chk_b(capture_ready, 1'b1, "trigger did not stop");
    chk_b(triggered, 1'b1, "trigger not flagged");
    wait_got(base + 16);
    for (int i = 0; i < 16; i++) chk_w(trace_sink_model_inst.got[base + i], 32'h204 + i, "wrap");
    capture_enable = 1'b0;
    tick(1);
    $display("test circular trigger done");
    // Let the memory variant finish its circular drain first
    tick(32);
    start(2'h3);
    chk_w({30'h0, axi_mode}, 32'h3, "memory fifo mode");
    for (int i = 0; i < 4; i++) send(32'h300 + i);
    trace_valid = 1'b0;
    tick(16);
    chk_w({21'h0, axi_wr_ptr}, 32'h4, "memory writes");
    chk_w(axi_addr, 32'hc, "last write address");
    chk_w(axi_wdata, 32'h303, "last write data");
    rurp_valid = 1'b1;
    rurp_words = 10'h3;
    tick(1);
    rurp_valid = 1'b0;
    chk_w({21'h0, axi_rd_ptr}, 32'h3, "read pointer report");
    capture_enable = 1'b0;
    tick(1);
    $display("test memory fifo done");
    results();
  end
endmodule
`default_nettype wire

/* File: trace_sink_model.sv */
// Trace sink model taking words at a chosen pace
`timescale 1ns/1ps
`default_nettype none
module trace_sink_model (
  input wire logic clk_sys, // System clock
  input wire logic reset_n, // Reset, active low
  input wire logic [1:0] pace, // 0 prompt, 1 slow, 2 stalled
  input wire logic sink_valid, // Word offered
  input wire logic [capture_pkg::DATA_W-1:0] sink_data, // Word
  output logic sink_ready // Word taken when high
);
  logic [capture_pkg::DATA_W-1:0] got [0:63];
  int n_got;
  logic odd;
  initial sink_ready = 1'b0;
  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      n_got <= 0;
      odd <= 1'b0;
    end else begin
      odd <= !odd;
      if (sink_valid && sink_ready) begin
        got[n_got] <= sink_data;
        n_got <= n_got + 1;
      end
    end
  end
  // Ready moves just after the edge
  always @(posedge clk_sys) begin
    sink_ready <= #1 (pace == 2'h0) || (pace == 2'h1 && odd);
  end
endmodule
`default_nettype wire

/* File: trace_stream_if.sv */
// Valid/ready word stream between the controller and its staging FIFO
`timescale 1ns/1ps
`default_nettype none
interface trace_stream_if #(parameter int WIDTH = 32);
  logic valid;
  logic ready;
  logic [WIDTH-1:0] data;
  modport source(output valid, output data, input ready);
  modport sink(input valid, input data, output ready);
endinterface
`default_nettype wire
